// ---- rtl/apl_pkg.sv ----
// Shared constants and types for the audio port level control block
package apl_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LOCK = 8'h04;
   localparam logic [7:0] ADDR_XMUTE = 8'h08;
   localparam logic [7:0] ADDR_OMUTE = 8'h0c;
   localparam logic [7:0] ADDR_ROUTE = 8'h10;
   localparam logic [7:0] ADDR_PRES = 8'h14;
   localparam logic [7:0] ADDR_VOLDB = 8'h18;
   localparam logic [7:0] ADDR_VOLPCT = 8'h1c;
   localparam logic [7:0] ADDR_BAL = 8'h20;
   localparam logic [7:0] ADDR_STEPDB = 8'h24;
   localparam logic [7:0] ADDR_STEPPCT = 8'h28;
   localparam logic [7:0] ADDR_STEPBAL = 8'h2c;
   // Field positions
   localparam int CTRL_FOLLOW_BIT = 0;
   localparam int CTRL_FVO_LSB = 8;
   localparam int OUT_PORT_BIT = 4;
   localparam int OMUTE_ANALOG_BIT = 0;
   localparam int OMUTE_VSIL_LSB = 1;
   localparam int OMUTE_ROUTED_BIT = 3;
   // Volume scale: dB values in eighths of a dB, one step is three eighths
   localparam int DB_STEP_EIGHTHS = 3;
   localparam int DB_MIN_EIGHTHS = -765;
   localparam logic [7:0] ATT_MAX = 8'hff;
   localparam int PCT_MAX = 100;
   localparam int BAL_MIN = -100;
   localparam int BAL_MAX = 100;
   localparam logic [2:0] NUM_INPUTS = 3'h4;
   // Reset values
   localparam logic [1:0] FVO_RESET = 2'h1;
   localparam logic [7:0] ATT_RESET = 8'h00;
   localparam logic signed [7:0] BAL_RESET = 8'sh00;
   localparam logic [2:0] ROUTE_RESET = 3'h0;

   typedef enum logic {
      APL_POLICY_OFF = 1'b0,
      APL_POLICY_FOLLOW = 1'b1
   } apl_policy_t;

   // Settings seen by the analog and routed audio paths
   typedef struct packed {
      logic [2:0] src;
      logic [7:0] att;
      logic signed [7:0] bal;
      logic [1:0] video_silence;
      logic routed_silence;
   } apl_out_t;
endpackage

// ---- rtl/apl_ctrl.sv ----
// Audio port level control: AHB-Lite registers, routing, mute, volume, balance
// Notes on behaviour
// - Autoselect policy is either follow video crosspoint or off.
// - A followed video output number is stored and reads back.
// - Each audio input and the output carry a lock blocking routing changes.
// - Crosspoint mute on a port suspends its connection, forwarding no audio.
// - Analog output mute drives the output volume to its lowest level.
// - Output port nodes have own mutes, including video embedded audio silence.
// - A readable presence flag exists for each audio input and output.
// - Decibel attenuation settable from lower limit to 0 dB in 0.375 dB steps.
// - Off-step decibel requests round upward to the nearest valid step.
// - Volume settable in percent, zero to full, one percent steps.
// - Balance is signed from -100 to 100, step one, reset to zero.
// - Relative decibel step adds signed step to current volume.
// - Relative percent step raises or lowers volume by signed percent.
// - Relative balance step shifts balance by signed step.
// - Selecting input zero disconnects the output.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module apl_ctrl (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [8:0] video_route_src,
   input wire logic [3:0] audio_presence_flag,
   output apl_pkg::apl_out_t level_out
);
   logic dph_valid_reg;
   logic dph_write_reg;
   logic [7:0] dph_addr_reg;
   logic rd_first_reg;
   logic [31:0] hrdata_reg;
   logic ap_take;
   logic wr_now;
   logic [31:0] rd_mux;
   apl_pkg::apl_policy_t policy_reg;
   logic [1:0] fvo_reg;
   logic [4:0] lock_reg;
   logic [4:0] xmute_reg;
   logic [3:0] omute_reg;
   logic [2:0] route_reg;
   logic [2:0] route_next;
   logic [7:0] att_reg;
   logic [7:0] att_next;
   logic signed [7:0] bal_reg;
   logic signed [7:0] bal_next;
   logic [2:0] follow_src;
   logic [2:0] eff_src;
   logic out_present;
   logic [6:0] pct_now;
   logic signed [17:0] db_now;
   apl_pkg::apl_out_t out_reg;

   // Decibel value in eighths to attenuation steps, rounding toward louder
   function automatic logic [7:0] db_to_att(input logic signed [17:0] v);
      logic [17:0] mag;
      mag = 18'h0;
      if (v >= 18'sh0) begin
         db_to_att = 8'h00;
      end else if (v <= 18'(apl_pkg::DB_MIN_EIGHTHS)) begin
         db_to_att = apl_pkg::ATT_MAX;
      end else begin
         mag = 18'(-v);
         db_to_att = 8'(mag / 18'(apl_pkg::DB_STEP_EIGHTHS));
      end
   endfunction

   // Percent to attenuation steps, floor keeps the louder step
   function automatic logic [7:0] pct_to_att(input logic signed [17:0] p);
      logic [17:0] down;
      down = 18'h0;
      if (p >= 18'(apl_pkg::PCT_MAX)) begin
         pct_to_att = 8'h00;
      end else if (p <= 18'sh0) begin
         pct_to_att = apl_pkg::ATT_MAX;
      end else begin
         down = 18'((18'(apl_pkg::PCT_MAX) - p) * 18'd255);
         pct_to_att = 8'(down / 18'(apl_pkg::PCT_MAX));
      end
   endfunction

   // Clamp a balance sum to its range
   function automatic logic signed [7:0] bal_clamp(input logic signed [17:0] b);
      if (b > 18'(apl_pkg::BAL_MAX)) begin
         bal_clamp = 8'(apl_pkg::BAL_MAX);
      end else if (b < 18'(apl_pkg::BAL_MIN)) begin
         bal_clamp = 8'(apl_pkg::BAL_MIN);
      end else begin
         bal_clamp = 8'(b);
      end
   endfunction

   // Address phase capture; reads take one wait state
   assign ap_take = hsel && htrans[1] && hready;
   assign hreadyout = !rd_first_reg;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign wr_now = dph_valid_reg && dph_write_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dph_valid_reg <= 1'b0;
         dph_write_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
         rd_first_reg <= 1'b0;
      end else begin
         if (ap_take) begin
            dph_valid_reg <= 1'b1;
            dph_write_reg <= hwrite;
            dph_addr_reg <= {haddr[7:2], 2'b00};
         end else if (hreadyout) begin
            dph_valid_reg <= 1'b0;
         end
         rd_first_reg <= ap_take && !hwrite;
      end
   end

   // Read data captured in the wait cycle so a preceding write is visible
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_first_reg) begin
         hrdata_reg <= rd_mux;
      end
   end

   // Current volume in both scales
   assign db_now = -18'(18'(att_reg) * 18'(apl_pkg::DB_STEP_EIGHTHS));
   assign pct_now = 7'(apl_pkg::PCT_MAX - ((32'(att_reg) * 100 + 127) / 255));

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (dph_addr_reg)
         apl_pkg::ADDR_CTRL: begin
            rd_mux[apl_pkg::CTRL_FOLLOW_BIT] = policy_reg;
            rd_mux[apl_pkg::CTRL_FVO_LSB +: 2] = fvo_reg;
         end
         apl_pkg::ADDR_LOCK: rd_mux[4:0] = lock_reg;
         apl_pkg::ADDR_XMUTE: rd_mux[4:0] = xmute_reg;
         apl_pkg::ADDR_OMUTE: rd_mux[3:0] = omute_reg;
         apl_pkg::ADDR_ROUTE: rd_mux[2:0] = route_reg;
         apl_pkg::ADDR_PRES: rd_mux[4:0] = {out_present, audio_presence_flag};
         apl_pkg::ADDR_VOLDB: rd_mux = 32'(db_now);
         apl_pkg::ADDR_VOLPCT: rd_mux[6:0] = pct_now;
         apl_pkg::ADDR_BAL: rd_mux = 32'(bal_reg);
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Policy, followed output, locks and mutes
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         policy_reg <= apl_pkg::APL_POLICY_OFF;
         fvo_reg <= apl_pkg::FVO_RESET;
         lock_reg <= 5'h00;
         xmute_reg <= 5'h00;
         omute_reg <= 4'h0;
      end else if (wr_now) begin
         if (dph_addr_reg == apl_pkg::ADDR_CTRL) begin
            policy_reg <= apl_pkg::apl_policy_t'(hwdata[apl_pkg::CTRL_FOLLOW_BIT]);
            fvo_reg <= hwdata[apl_pkg::CTRL_FVO_LSB +: 2];
         end
         if (dph_addr_reg == apl_pkg::ADDR_LOCK) begin
            lock_reg <= hwdata[4:0];
         end
         if (dph_addr_reg == apl_pkg::ADDR_XMUTE) begin
            xmute_reg <= hwdata[4:0];
         end
         if (dph_addr_reg == apl_pkg::ADDR_OMUTE) begin
            omute_reg <= hwdata[3:0];
         end
      end
   end

   // Source that the followed video output currently shows
   always_comb begin
      unique case (fvo_reg)
         2'h2: follow_src = video_route_src[5:3];
         2'h3: follow_src = video_route_src[8:6];
         default: follow_src = video_route_src[2:0];
      endcase
   end

   // Route selection: locks freeze it, follow overrides software writes
   always_comb begin
      route_next = route_reg;
      if (policy_reg == apl_pkg::APL_POLICY_FOLLOW) begin
         route_next = follow_src;
      end else if (wr_now && dph_addr_reg == apl_pkg::ADDR_ROUTE) begin
         route_next = hwdata[2:0];
      end
      if (route_next > apl_pkg::NUM_INPUTS) begin
         route_next = route_reg;
      end
      if (lock_reg[apl_pkg::OUT_PORT_BIT]) begin
         route_next = route_reg;
      end
      if (route_reg != 3'h0 && lock_reg[2'(route_reg - 3'h1)]) begin
         route_next = route_reg;
      end
      if (route_next != 3'h0 && lock_reg[2'(route_next - 3'h1)]) begin
         route_next = route_reg;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         route_reg <= apl_pkg::ROUTE_RESET;
      end else begin
         route_reg <= route_next;
      end
   end

   // Volume: absolute and relative, in decibels or percent
   always_comb begin
      att_next = att_reg;
      if (wr_now) begin
         unique case (dph_addr_reg)
            apl_pkg::ADDR_VOLDB: att_next = db_to_att(18'(signed'(hwdata[15:0])));
            apl_pkg::ADDR_VOLPCT: att_next = pct_to_att(18'(signed'(hwdata[15:0])));
            apl_pkg::ADDR_STEPDB: att_next = db_to_att(db_now + 18'(signed'(hwdata[15:0])));
            apl_pkg::ADDR_STEPPCT: att_next = pct_to_att(18'(pct_now) + 18'(signed'(hwdata[15:0])));
            default: att_next = att_reg;
         endcase
      end
   end

   // Balance: absolute and relative, both clamped
   always_comb begin
      bal_next = bal_reg;
      if (wr_now && dph_addr_reg == apl_pkg::ADDR_BAL) begin
         bal_next = bal_clamp(18'(signed'(hwdata[15:0])));
      end else if (wr_now && dph_addr_reg == apl_pkg::ADDR_STEPBAL) begin
         bal_next = bal_clamp(18'(bal_reg) + 18'(signed'(hwdata[15:0])));
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         att_reg <= apl_pkg::ATT_RESET;
         bal_reg <= apl_pkg::BAL_RESET;
      end else begin
         att_reg <= att_next;
         bal_reg <= bal_next;
      end
   end

   // Effective source: zero or a muted port leaves the output silent
   always_comb begin
      eff_src = route_reg;
      if (route_reg == 3'h0) begin
         eff_src = 3'h0;
      end else if (xmute_reg[2'(route_reg - 3'h1)] || xmute_reg[apl_pkg::OUT_PORT_BIT]) begin
         eff_src = 3'h0;
      end
   end

   assign out_present = (eff_src != 3'h0) && audio_presence_flag[2'(eff_src - 3'h1)];

   // Registered settings toward the audio paths
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         out_reg <= '0;
      end else begin
         out_reg.src <= eff_src;
         out_reg.att <= omute_reg[apl_pkg::OMUTE_ANALOG_BIT] ? apl_pkg::ATT_MAX : att_reg;
         out_reg.bal <= bal_reg;
         out_reg.video_silence <= omute_reg[apl_pkg::OMUTE_VSIL_LSB +: 2];
         out_reg.routed_silence <= omute_reg[apl_pkg::OMUTE_ROUTED_BIT];
      end
   end

   assign level_out = out_reg;

   // Checks on the guarded behaviour
   mute_low_a: assert property (@(posedge clock) disable iff (!rst_b)
      omute_reg[0] |=> level_out.att == 8'hff)
      else $error("Analog mute did not force lowest level");
   xp_mute_a: assert property (@(posedge clock) disable iff (!rst_b)
      xmute_reg[4] |=> level_out.src == 3'h0)
      else $error("Muted output still forwards a source");
   route_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
      route_reg == 3'h0 |=> level_out.src == 3'h0)
      else $error("Input zero did not disconnect output");
   bal_range_a: assert property (@(posedge clock) disable iff (!rst_b)
      bal_reg >= -8'sd100 && bal_reg <= 8'sd100)
      else $error("Balance left its range");
   lock_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      lock_reg[4] |=> $stable(route_reg))
      else $error("Locked output changed its route");
   follow_track_a: assert property (@(posedge clock) disable iff (!rst_b)
      policy_reg && lock_reg == 5'h00 && follow_src <= 3'h4 |=> route_reg == $past(follow_src))
      else $error("Follow policy did not track video");
   db_round_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_now && dph_addr_reg == 8'h18 && hwdata[15] && hwdata[15:0] >= 16'hfffe
      |=> att_reg == 8'h00)
      else $error("Decibel request not rounded upward");
   db_sat_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_now && dph_addr_reg == 8'h24 && att_reg == 8'hff && hwdata[15] |=> att_reg == 8'hff)
      else $error("Decibel step wrapped past the limit");
   bal_step_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_now && dph_addr_reg == 8'h2c && hwdata[15:0] == 16'h0005 && bal_reg <= 8'sd95
      |=> bal_reg == $past(bal_reg) + 8'sd5)
      else $error("Balance step not applied");
   pres_read_a: assert property (@(posedge clock) disable iff (!rst_b)
      rd_first_reg && dph_addr_reg == 8'h14 |=> hrdata[3:0] == $past(audio_presence_flag))
      else $error("Presence flags misread");
   read_wait_a: assert property (@(posedge clock) disable iff (!rst_b)
      ap_take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state not exactly one cycle");
   // Writes never stall, locks and the off policy keep the route still
   write_ready_a: assert property (@(posedge clock) disable iff (!rst_b)
      ap_take && hwrite |=> hreadyout)
      else $error("Write data phase was stalled");
   in_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
      route_reg != 3'h0 && lock_reg[2'(route_reg - 3'h1)] |=> $stable(route_reg))
      else $error("Locked input lost its route");
   follow_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      !policy_reg && !(wr_now && dph_addr_reg == apl_pkg::ADDR_ROUTE) |=> $stable(route_reg))
      else $error("Route moved with autoselect off");
   node_mute_a: assert property (@(posedge clock) disable iff (!rst_b)
      1'b1 |=> level_out.video_silence == $past(omute_reg[2:1])
         && level_out.routed_silence == $past(omute_reg[3]))
      else $error("Port node mutes not passed to the outputs");

   follow_cov_c: cover property (@(posedge clock) disable iff (!rst_b)
      policy_reg && $changed(route_reg));
   step_db_c: cover property (@(posedge clock) disable iff (!rst_b)
      wr_now && dph_addr_reg == 8'h24 ##1 $changed(att_reg));
   mute_cov_c: cover property (@(posedge clock) disable iff (!rst_b)
      $rose(omute_reg[0]));
   bal_cov_c: cover property (@(posedge clock) disable iff (!rst_b)
      bal_reg == 8'sd100);
endmodule
`default_nettype wire

// ---- dv/apl_ctrl_tb.sv ----
// Self-checking bench for the audio port level control block over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module apl_ctrl_tb;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] video_route_src = 9'h000;
   logic [3:0] audio_presence_flag = 4'h0;
   wire logic hready;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   apl_pkg::apl_out_t lvl;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] v;
   logic [7:0] ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
      8'h24, 8'h30};
   logic [31:0] rv[11] = '{32'h100, 0, 0, 0, 0, 0, 0, 32'h64, 0, 0, 0};
   int dbi[5] = '{-120, -1, -4, -766, 5};
   int dba[5] = '{40, 0, 1, 255, 0};
   int dbr[5] = '{-120, 0, -3, -765, 0};

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   apl_ctrl dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .video_route_src(video_route_src), .audio_presence_flag(audio_presence_flag),
      .level_out(lvl));

   // 125 MHz clock
   initial begin
      forever #4 clock = ~clock;
   end

   // Closing report, reached from the main sequence or the hang guard
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         $display("[FAIL] t=%0t run did not finish in time", $time);
         mismatches++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Ends one edge after ready is seen high; data is sampled mid-cycle, stable to that edge
   task automatic wait_ready(output logic [31:0] d);
      logic r;
      r = 1'b0;
      do begin
         @(negedge clock);
         r = hreadyout;
         d = hrdata;
         @(posedge clock);
      end while (r !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      wait_ready(x);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready(x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [31:0] x;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      wait_ready(x);
      hsel <= 1'b0;
      htrans <= 2'b00;
      wait_ready(d);
   endtask

   // Register read against an expected word
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp, "register read");
   endtask

   // Level outputs trail the registers by one edge; let them settle
   task automatic settle();
      repeat (3) @(posedge clock);
   endtask

   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      // Reset values, the write-only decibel step word reading zero, unmapped word
      chk({11'h0, lvl}, 32'h0, "level after reset");
      for (int i = 0; i < 11; i++) begin
         rc(ra[i], rv[i]);
      end
      // Follow policy tracks video output 2, host routing ignored
      video_route_src <= 9'h09c;
      wr(8'h00, 32'h201);
      rc(8'h00, 32'h201);
      settle();
      chk({29'h0, lvl.src}, 32'h3, "follow source");
      wr(8'h10, 32'h1);
      settle();
      chk({29'h0, lvl.src}, 32'h3, "route while following");
      wr(8'h00, 32'h301);
      settle();
      chk({29'h0, lvl.src}, 32'h2, "follow output 3");
      wr(8'h00, 32'h001);
      rc(8'h00, 32'h001);
      settle();
      chk({29'h0, lvl.src}, 32'h4, "follow output 0 as 1");
      wr(8'h00, 32'h200);
      // Input zero disconnects
      wr(8'h10, 32'h0);
      settle();
      chk({29'h0, lvl.src}, 32'h0, "input zero");
      wr(8'h10, 32'h2);
      settle();
      chk({29'h0, lvl.src}, 32'h2, "route to two");
      // Locks on current input, new input and output
      wr(8'h04, 32'h02);
      rc(8'h04, 32'h02);
      wr(8'h10, 32'h4);
      wr(8'h04, 32'h08);
      wr(8'h10, 32'h4);
      wr(8'h04, 32'h10);
      wr(8'h10, 32'h1);
      settle();
      chk({29'h0, lvl.src}, 32'h2, "locked route");
      wr(8'h04, 32'h00);
      // Presence of inputs and of the routed output
      audio_presence_flag <= 4'h2;
      settle();
      rc(8'h14, 32'h12);
      // Crosspoint mute suspends the routed input
      wr(8'h08, 32'h02);
      settle();
      chk({29'h0, lvl.src}, 32'h0, "crosspoint mute");
      rc(8'h14, 32'h02);
      wr(8'h08, 32'h10);
      settle();
      chk({29'h0, lvl.src}, 32'h0, "output crosspoint mute");
      wr(8'h08, 32'h00);
      // Analog mute and the port node mutes
      wr(8'h18, 32'hffffff88);
      wr(8'h0c, 32'h01);
      settle();
      chk({24'h0, lvl.att}, 32'hff, "analog mute");
      rc(8'h18, 32'hffffff88);
      wr(8'h0c, 32'h0e);
      settle();
      chk({16'h0, lvl.att, 5'h0, lvl.video_silence, lvl.routed_silence}, 32'h2807,
         "node mutes");
      wr(8'h0c, 32'h00);
      // Decibel settings with rounding and limits
      for (int i = 0; i < 5; i++) begin
         wr(8'h18, dbi[i]);
         settle();
         chk({24'h0, lvl.att}, dba[i], "dB attenuation");
         rc(8'h18, dbr[i]);
      end
      // Percent settings
      wr(8'h1c, 32'd50);
      settle();
      chk({24'h0, lvl.att}, 32'd127, "percent att");
      rc(8'h1c, 32'd50);
      wr(8'h1c, 32'd0);
      rc(8'h1c, 32'd0);
      // Relative percent steps with saturation
      wr(8'h1c, 32'd50);
      wr(8'h28, 32'd5);
      settle();
      chk({24'h0, lvl.att}, 32'd114, "percent step");
      rc(8'h1c, 32'd55);
      wr(8'h28, -200);
      rc(8'h1c, 32'd0);
      wr(8'h28, 32'd300);
      rc(8'h1c, 32'd100);
      // Relative decibel steps with saturation
      wr(8'h18, 32'h0);
      wr(8'h24, -8);
      settle();
      chk({24'h0, lvl.att}, 32'd2, "dB step");
      rc(8'h18, -6);
      wr(8'h24, 32'd100);
      rc(8'h18, 32'h0);
      wr(8'h24, -1000);
      settle();
      chk({24'h0, lvl.att}, 32'hff, "dB step floor");
      wr(8'h24, -8);
      rc(8'h18, -765);
      // Balance, steps and clamping
      wr(8'h20, -100);
      wr(8'h2c, 32'd5);
      settle();
      chk({{24{lvl.bal[7]}}, lvl.bal}, -95, "balance step");
      rc(8'h20, -95);
      wr(8'h20, 32'd200);
      rc(8'h20, 32'd100);
      wr(8'h2c, 32'd5);
      rc(8'h20, 32'd100);
      wr(8'h2c, -250);
      rc(8'h20, -100);
      chk({31'h0, hresp}, 32'h0, "response code");
      give_verdict();
   end
endmodule
`default_nettype wire
